// File: rtl/bms_buck_controller_mode_sequencer.sv
// bms_buck_controller_mode_sequencer: gate sequencing, config latch, phase clock,
// light-load modes, sync lock and thermal sequence of a step-down controller.
// assumes comparator flags on pinsIn and an Avalon-MM master on the register port.
`timescale 1ns/10ps

// Summary of operation
// - high and low drive never on together
// - high off, wait level low, delay, low on
// - high on only after low level low
// - latch config at supply good, hold until loss
// - decode five config codes into mode bits
// - primary with spread refuses external sync
// - config pin then sets noise filter enable
// - secondary disables its error amplifier output
// - dual phase forbids internal compensation option
// - primary emits 180 degree clock, secondary follows
// - late sync locks after two clock cycles
// - pulse skipping stops the phase clock output
// - re-enable holds soft-start low, then restarts
// - sixteen missed cycles enter sleep, not forced
// - diode emulation cuts low drive on reverse
// - mode pin selects skip, forced or sync
// - pre-bias forces emulation, ramps to continuous
// - sync followed within 20 percent, 2.5 MHz
// - minimum off time ignores sync, stretches cycle
// - over-temperature shuts down, restarts with hysteresis
module bms_buck_controller_mode_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire bms_pkg::bms_pins_t pinsIn,
  input wire logic [3:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWritedata,
  output logic [31:0] avReaddata,
  output logic avWaitrequest,
  output logic highSideDrive,
  output logic lowSideDrive,
  output logic powerGoodPhaseOut,
  output logic powerGoodPhaseOe,
  output logic errAmpEnable,
  output logic intCompEnable,
  output logic activeNoiseFilter,
  output logic sleepState,
  output logic softStartHold,
  output logic gateRegEnable,
  output logic spreadEnable
);
  import bms_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    bms_pins_t sy1;
    bms_pins_t sy2;
    bms_pins_t sy3;
    bms_pins_t filt;
    logic modePrev;
    logic phasePrev;
    bms_gate_t gate;
    logic pendHs;
    logic [7:0] deadCnt;
    logic [2:0] settle;
    logic hsOut;
    logic lsOut;
    logic spreadOut;
    logic [15:0] cycCnt;
    logic [16:0] syncGap;
    logic [1:0] syncEdges;
    logic syncSeen;
    logic cfgLatched;
    bms_cfg_t cfg;
    logic noiseFilter;
    logic [4:0] missCnt;
    logic sleep;
    logic [3:0] rampCnt;
    logic [3:0] cycleIdx;
    logic thermalShut;
    logic pgOut;
    logic pgOe;
    logic errAmpEn;
    logic intCompEn;
    logic ssHold;
    logic gateRegEn;
    logic runCtrl;
    logic [15:0] period;
    logic [7:0] deadCfg;
    logic waitReq;
    logic [31:0] rdData;
  } bms_state_t;

  bms_state_t st;
  bms_state_t next_st;

  always_comb begin
    bms_pins_t f;
    bms_cfg_t dec;
    logic modeRise;
    logic phaseRise;
    logic syncLocked;
    logic syncAllowed;
    logic syncToggling;
    logic oscWrap;
    logic cycleStart;
    logic running;
    logic pulseSkipSel;
    logic rampDe;
    logic deActive;
    logic inRange;
    logic [20:0] gap5;
    logic [20:0] perLo;
    logic [20:0] perHi;
    logic [31:0] rdVal;
    f = st.filt;
    dec = '0;
    modeRise = 1'b0;
    phaseRise = 1'b0;
    syncLocked = 1'b0;
    syncAllowed = 1'b0;
    syncToggling = 1'b0;
    oscWrap = 1'b0;
    cycleStart = 1'b0;
    running = 1'b0;
    pulseSkipSel = 1'b0;
    rampDe = 1'b0;
    deActive = 1'b0;
    inRange = 1'b0;
    gap5 = '0;
    perLo = '0;
    perHi = '0;
    rdVal = '0;
    next_st = st;

    // ----------------------------------------
    // input synchronisers and agreement filter
    // ----------------------------------------
    next_st.sy1 = pinsIn;
    next_st.sy2 = st.sy1;
    next_st.sy3 = st.sy2;
    next_st.filt = (st.sy2 & st.sy3) | (st.filt & (st.sy2 | st.sy3));
    next_st.modePrev = f.modePinLevel;
    next_st.phasePrev = f.phaseClockIn;
    modeRise = f.modePinLevel & ~st.modePrev;
    phaseRise = f.phaseClockIn & ~st.phasePrev;

    // ----------------------------------------
    // configuration latch and noise filter enable
    // ----------------------------------------
    unique case (f.cfgCode)
      CFG_P_SS_SINGLE: dec = '{secondary: 1'b0, spread: 1'b1, dual: 1'b0};
      CFG_P_NOSS_DUAL: dec = '{secondary: 1'b0, spread: 1'b0, dual: 1'b1};
      CFG_P_SS_DUAL: dec = '{secondary: 1'b0, spread: 1'b1, dual: 1'b1};
      CFG_SECONDARY: dec = '{secondary: 1'b1, spread: 1'b0, dual: 1'b1};
      default: dec = '{secondary: 1'b0, spread: 1'b0, dual: 1'b0};
    endcase
    if (!f.gateSupplyOk) begin
      next_st.cfgLatched = 1'b0;
    end else if (!st.cfgLatched) begin
      next_st.cfgLatched = 1'b1;
      next_st.cfg = dec;
    end
    if (st.cfgLatched && f.cfgPinHigh) begin
      next_st.noiseFilter = 1'b1;
    end else if (!st.cfgLatched || f.cfgPinLow) begin
      next_st.noiseFilter = 1'b0;
    end
    next_st.errAmpEn = st.cfgLatched && !st.cfg.secondary;
    next_st.intCompEn = st.cfgLatched && !st.cfg.dual && f.intCompDetected;

    // ----------------------------------------
    // thermal sequence and run condition
    // ----------------------------------------
    if (f.overTemp) begin
      next_st.thermalShut = 1'b1;
    end else if (f.tempRecovered) begin
      next_st.thermalShut = 1'b0;
    end
    next_st.gateRegEn = !st.thermalShut;
    running = st.cfgLatched && f.enablePin && st.runCtrl && !st.thermalShut;
    next_st.ssHold = !running;

    // ----------------------------------------
    // external sync detection and lock
    // ----------------------------------------
    gap5 = 21'(st.syncGap) * 21'd5;
    perLo = 21'(st.period) * 21'(100 - SYNC_TOL_PCT) / 21'd20;
    perHi = 21'(st.period) * 21'(100 + SYNC_TOL_PCT) / 21'd20;
    inRange = (gap5 >= perLo) && (gap5 <= perHi) && (st.syncGap >= 17'(SYNC_MIN_CYC));
    if (modeRise) begin
      next_st.syncGap = '0;
      next_st.syncSeen = 1'b1;
      if (inRange && st.syncSeen) begin
        if (st.syncEdges != 2'(SYNC_LOCK_EDGES)) begin
          next_st.syncEdges = st.syncEdges + 2'd1;
        end
      end else begin
        next_st.syncEdges = '0;
      end
    end else if (st.syncGap > {st.period, 1'b0}) begin
      next_st.syncSeen = 1'b0;
      next_st.syncEdges = '0;
    end else begin
      next_st.syncGap = st.syncGap + 17'd1;
    end
    syncToggling = st.syncSeen;
    syncAllowed = !(!st.cfg.secondary && st.cfg.spread);
    syncLocked = (st.syncEdges == 2'(SYNC_LOCK_EDGES)) && syncAllowed;
    pulseSkipSel = !syncToggling && f.modePinLevel;

    // ----------------------------------------
    // switching cycle source
    // ----------------------------------------
    oscWrap = (st.cycCnt >= st.period - 16'd1) && !f.minOffReached;
    if (st.cfg.secondary) begin
      cycleStart = phaseRise;
    end else if (syncLocked && syncAllowed && !f.minOffReached) begin
      cycleStart = modeRise;
    end else begin
      cycleStart = oscWrap;
    end
    if (cycleStart) begin
      next_st.cycCnt = '0;
      next_st.cycleIdx = st.cycleIdx + 4'd1;
    end else if (st.cycCnt != 16'hffff) begin
      next_st.cycCnt = st.cycCnt + 16'd1;
    end

    // ----------------------------------------
    // diode emulation, pre-bias ramp, sleep
    // ----------------------------------------
    if (f.preBias || !running) begin
      next_st.rampCnt = '0;
    end else if (cycleStart && st.rampCnt != 4'(RAMP_STEPS)) begin
      next_st.rampCnt = st.rampCnt + 4'd1;
    end
    rampDe = (st.rampCnt != 4'(RAMP_STEPS)) && (st.cycleIdx >= st.rampCnt);
    deActive = pulseSkipSel || f.preBias || rampDe;
    if (!running || !deActive || f.cycleDemand) begin
      next_st.missCnt = '0;
    end else if (cycleStart && st.missCnt != 5'(SLEEP_MISSES)) begin
      next_st.missCnt = st.missCnt + 5'd1;
    end
    next_st.sleep = pulseSkipSel && running && (st.missCnt == 5'(SLEEP_MISSES))
      && !f.cycleDemand;

    // ----------------------------------------
    // adaptive dead-time gate sequencer
    // ----------------------------------------
    // a drive-level flag is stale until the synchronisers have seen the drive switch
    if (st.settle != 3'(FLAG_LAT)) begin
      next_st.settle = st.settle + 3'd1;
    end
    if (!running || st.sleep) begin
      next_st.gate = GATE_OFF;
      next_st.pendHs = 1'b0;
    end else begin
      unique case (st.gate)
        GATE_OFF: begin
          if (cycleStart && f.cycleDemand) begin
            next_st.pendHs = 1'b1;
            next_st.gate = GATE_LS_FALL;
            next_st.settle = '0;
          end
        end
        GATE_LS_FALL: begin
          if (f.lowDriveLow && st.settle == 3'(FLAG_LAT)) begin
            next_st.gate = st.pendHs ? GATE_HS_ON : GATE_OFF;
            next_st.pendHs = 1'b0;
          end
        end
        GATE_HS_ON: begin
          if (f.pwmTrip || cycleStart) begin
            next_st.gate = GATE_HS_FALL;
            next_st.deadCnt = '0;
            next_st.settle = '0;
          end
        end
        GATE_HS_FALL: begin
          if (f.highDriveLow && st.settle == 3'(FLAG_LAT)) begin
            if (st.deadCnt >= st.deadCfg) begin
              next_st.gate = GATE_LS_ON;
            end else begin
              next_st.deadCnt = st.deadCnt + 8'd1;
            end
          end
        end
        GATE_LS_ON: begin
          if (deActive && f.reverseCurrent) begin
            next_st.gate = GATE_LS_FALL;
            next_st.pendHs = 1'b0;
            next_st.settle = '0;
          end else if (cycleStart && f.cycleDemand) begin
            next_st.gate = GATE_LS_FALL;
            next_st.pendHs = 1'b1;
            next_st.settle = '0;
          end
        end
        default: next_st.gate = GATE_OFF;
      endcase
    end
    next_st.hsOut = (next_st.gate == GATE_HS_ON);
    next_st.lsOut = (next_st.gate == GATE_LS_ON);
    next_st.spreadOut = next_st.cfgLatched && next_st.cfg.spread && !next_st.cfg.secondary;

    // ----------------------------------------
    // power-good / phase clock pin
    // ----------------------------------------
    if (st.thermalShut || !st.cfgLatched) begin
      next_st.pgOut = 1'b0;
      next_st.pgOe = 1'b1;
    end else if (st.cfg.dual && !st.cfg.secondary) begin
      if (!running || (pulseSkipSel && (st.missCnt != 5'd0 || st.sleep))) begin
        next_st.pgOut = 1'b0;
        next_st.pgOe = 1'b0;
      end else begin
        next_st.pgOut = (st.cycCnt >= {1'b0, st.period[15:1]});
        next_st.pgOe = 1'b1;
      end
    end else begin
      next_st.pgOut = 1'b0;
      next_st.pgOe = !f.outputOk;
    end

    // ----------------------------------------
    // Avalon-MM slave
    // ----------------------------------------
    unique case (avAddress)
      REG_CTRL: rdVal = {31'h0, st.runCtrl};
      REG_PERIOD: rdVal = {16'h0, st.period};
      REG_DEAD: rdVal = {24'h0, st.deadCfg};
      REG_STATUS: rdVal = {15'h0, st.gate, st.missCnt, st.thermalShut, st.sleep,
        syncLocked, pulseSkipSel, st.noiseFilter, st.cfg, st.cfgLatched};
      default: rdVal = '0;
    endcase
    next_st.waitReq = !((avRead || avWrite) && st.waitReq);
    if (avRead && st.waitReq) begin
      next_st.rdData = rdVal;
    end
    if (avWrite && !st.waitReq) begin
      unique case (avAddress)
        REG_CTRL: next_st.runCtrl = avWritedata[CTRL_RUN_BIT];
        REG_PERIOD: next_st.period = avWritedata[15:0];
        REG_DEAD: next_st.deadCfg = avWritedata[7:0];
        default: next_st.runCtrl = st.runCtrl;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
      st.gate <= GATE_OFF;
      st.pgOe <= 1'b1;
      st.ssHold <= 1'b1;
      st.gateRegEn <= 1'b1;
      st.runCtrl <= CTRL_RUN_RST;
      st.period <= PERIOD_RST;
      st.deadCfg <= DEAD_RST;
      st.waitReq <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign highSideDrive = st.hsOut;
  assign lowSideDrive = st.lsOut;
  assign powerGoodPhaseOut = st.pgOut;
  assign powerGoodPhaseOe = st.pgOe;
  assign errAmpEnable = st.errAmpEn;
  assign intCompEnable = st.intCompEn;
  assign activeNoiseFilter = st.noiseFilter;
  assign sleepState = st.sleep;
  assign softStartHold = st.ssHold;
  assign gateRegEnable = st.gateRegEn;
  assign spreadEnable = st.spreadOut;
  assign avReaddata = st.rdData;
  assign avWaitrequest = st.waitReq;

endmodule // bms_buck_controller_mode_sequencer

// File: rtl/bms_pkg.sv
// bms_pkg: constants, types and register map of the buck mode sequencer.
// assumes one 100 MHz clock; analog thresholds arrive as comparator flags.
package bms_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int DEAD_NS = 20;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_MAX_KHZ = 2500;
  localparam int SYNC_MIN_CYC = (CLK_MHZ * 1000 + SYNC_MAX_KHZ - 1) / SYNC_MAX_KHZ;
  localparam int SYNC_TOL_PCT = 20;
  localparam int SYNC_LOCK_EDGES = 2;
  localparam int SLEEP_MISSES = 16;
  // cycles a drive-level flag needs to pass the input synchronisers
  localparam int FLAG_LAT = 4;
  localparam int RAMP_STEPS = 15;
  localparam logic [15:0] PERIOD_RST = 16'h01f4;
  localparam logic [7:0] DEAD_RST = 8'(DEAD_CYC);

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PERIOD = 4'h4;
  localparam logic [3:0] REG_DEAD = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b1;

  // ----------------------------------------
  // configuration select codes
  // ----------------------------------------
  localparam logic [2:0] CFG_P_NOSS_SINGLE = 3'h0;
  localparam logic [2:0] CFG_P_SS_SINGLE = 3'h1;
  localparam logic [2:0] CFG_P_NOSS_DUAL = 3'h2;
  localparam logic [2:0] CFG_P_SS_DUAL = 3'h3;
  localparam logic [2:0] CFG_SECONDARY = 3'h4;

  typedef struct packed {
    logic secondary;
    logic spread;
    logic dual;
  } bms_cfg_t;

  // comparator flags and pin levels from the analog front end
  typedef struct packed {
    logic gateSupplyOk;
    logic highDriveLow;
    logic lowDriveLow;
    logic overTemp;
    logic tempRecovered;
    logic reverseCurrent;
    logic minOffReached;
    logic modePinLevel;
    logic phaseClockIn;
    logic enablePin;
    logic preBias;
    logic pwmTrip;
    logic cycleDemand;
    logic cfgPinHigh;
    logic cfgPinLow;
    logic intCompDetected;
    logic outputOk;
    logic [2:0] cfgCode;
  } bms_pins_t;

  typedef enum logic [2:0] {
    GATE_OFF = 3'b000,
    GATE_LS_FALL = 3'b001,
    GATE_HS_ON = 3'b011,
    GATE_HS_FALL = 3'b010,
    GATE_LS_ON = 3'b110
  } bms_gate_t;

endpackage

// File: test/bms_asserts.sv
// bms_asserts: port checker of the buck mode sequencer.
// assumes a bind to the top module; one clock domain.
`timescale 1ns/10ps
module bms_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire bms_pkg::bms_pins_t pinsIn,
  input wire logic highSideDrive,
  input wire logic lowSideDrive,
  input wire logic powerGoodPhaseOut,
  input wire logic errAmpEnable,
  input wire logic intCompEnable,
  input wire logic activeNoiseFilter,
  input wire logic sleepState,
  input wire logic softStartHold,
  input wire logic gateRegEnable,
  input wire logic spreadEnable
);
  import bms_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // gate drive
  // ----------------------------------------
  a_no_cross: assert property (!(highSideDrive && lowSideDrive))
    else $error("both drives on");
  a_low_after_high: assert property ($rose(lowSideDrive) |->
    !highSideDrive && $past(pinsIn.highDriveLow, 4)) else $error("low drive too early");
  a_high_after_low: assert property ($rose(highSideDrive) |->
    $past(pinsIn.lowDriveLow, 4)) else $error("high drive too early");
  a_reverse_cut: assert property ((pinsIn.modePinLevel && pinsIn.reverseCurrent)[*8]
    ##0 lowSideDrive |=> !lowSideDrive) else $error("low drive kept on reverse current");
  a_sleep_quiet: assert property (sleepState[*3] |->
    !highSideDrive && !lowSideDrive) else $error("switching while asleep");
  a_thermal_off: assert property (pinsIn.overTemp[*8] |-> ##1
    !highSideDrive && !lowSideDrive && !gateRegEnable && softStartHold && !powerGoodPhaseOut)
    else $error("thermal shutdown incomplete");
  // ----------------------------------------
  // configuration
  // ----------------------------------------
  sequence fresh_cfg;
    !pinsIn.gateSupplyOk ##1 (pinsIn.gateSupplyOk && $stable(pinsIn.cfgCode))[*8];
  endsequence
  a_spread_decode: assert property (fresh_cfg |-> ##2
    spreadEnable == (pinsIn.cfgCode == CFG_P_SS_SINGLE || pinsIn.cfgCode == CFG_P_SS_DUAL))
    else $error("spread decode wrong");
  a_secondary_amp: assert property (fresh_cfg ##0 pinsIn.cfgCode == CFG_SECONDARY |-> ##2
    !errAmpEnable) else $error("secondary amplifier enabled");
  a_dual_nocomp: assert property (fresh_cfg ##0 pinsIn.cfgCode >= CFG_P_NOSS_DUAL |-> ##2
    !intCompEnable) else $error("internal compensation in dual phase");
  a_filter_on: assert property (pinsIn.gateSupplyOk[*8] ##1
    (pinsIn.gateSupplyOk && pinsIn.cfgPinHigh)[*8] |-> activeNoiseFilter)
    else $error("noise filter not enabled");
  c_low_on: cover property ($rose(lowSideDrive));
  c_sleep: cover property ($rose(sleepState));
  c_filter: cover property ($rose(activeNoiseFilter));
endmodule // bms_asserts

// File: test/bms_power_stage.sv
// bms_power_stage: gate-level feedback of the external MOSFETs.
// assumes drive commands from the sequencer; slow stretches discharge.
`timescale 1ns/10ps
module bms_power_stage (
  input wire logic clk,
  input wire logic slow,
  input wire logic highSideDrive,
  input wire logic lowSideDrive,
  output logic highDriveLow,
  output logic lowDriveLow
);
  logic [3:0] hiCnt = 4'hf;
  logic [3:0] loCnt = 4'hf;
  // gate charge takes a few cycles to bleed below threshold
  always @(posedge clk) begin
    hiCnt <= highSideDrive ? 4'h0 : (hiCnt == 4'hf ? hiCnt : hiCnt + 4'h1);
    loCnt <= lowSideDrive ? 4'h0 : (loCnt == 4'hf ? loCnt : loCnt + 4'h1);
  end
  assign highDriveLow = hiCnt > (slow ? 4'h6 : 4'h1);
  assign lowDriveLow = loCnt > (slow ? 4'h6 : 4'h1);
endmodule // bms_power_stage

// File: test/bms_buck_controller_mode_sequencer_test.sv
// bms_buck_controller_mode_sequencer_test: self-checking bench of the sequencer.
// assumes the power stage model closes the gate-level loop.
`timescale 1ns/10ps
module bms_buck_controller_mode_sequencer_test;
  import bms_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  bms_pins_t pins = '0;
  bms_pins_t dutPins;
  logic [3:0] adr = '0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic avWait, hs, ls, pgOut, pgOe, errAmp, intComp, filt, slp, ssHold, regEn, spread;
  logic hiLow, loLow;
  logic syncOn = 0;
  logic [63:0] expQ[$];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int nHs = 0;
  int nLs = 0;
  int nPg = 0;
  always #5 clk = ~clk;
  always_comb begin
    dutPins = pins;
    dutPins.highDriveLow = hiLow;
    dutPins.lowDriveLow = loLow;
  end
  bms_buck_controller_mode_sequencer i_dut (.clk(clk), .rst_n(rst_n), .pinsIn(dutPins),
    .avAddress(adr), .avRead(rd), .avWrite(wr), .avWritedata(wdat), .avReaddata(rdat),
    .avWaitrequest(avWait), .highSideDrive(hs), .lowSideDrive(ls), .powerGoodPhaseOut(pgOut),
    .powerGoodPhaseOe(pgOe), .errAmpEnable(errAmp), .intCompEnable(intComp),
    .activeNoiseFilter(filt), .sleepState(slp), .softStartHold(ssHold),
    .gateRegEnable(regEn), .spreadEnable(spread));
  bms_power_stage i_stage (.clk(clk), .slow(cyc[9]), .highSideDrive(hs),
    .lowSideDrive(ls), .highDriveLow(hiLow), .lowDriveLow(loLow));
  // ----------------------------------------
  // tasks and monitors
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    if (!w) expQ.push_back({m, e});
    do @(posedge clk); while (avWait !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic relatch(input logic [2:0] c);
    pins.gateSupplyOk <= 1'b0;
    tick(8);
    pins.cfgCode <= c;
    tick(2);
    pins.gateSupplyOk <= 1'b1;
    tick(14);
  endtask
  always @(posedge clk) begin
    logic [63:0] e;
    if (rd && avWait === 1'b0) begin
      e = expQ.pop_front();
      chk(rdat & e[63:32], e[31:0]);
    end
  end
  always @(posedge hs) nHs++;
  always @(posedge ls) nLs++;
  always @(posedge pgOut) nPg++;
  always @(posedge clk) pins.pwmTrip <= hs && ($urandom % 4 == 0);
  always @(posedge clk) if (syncOn && cyc % 25 == 0) pins.modePinLevel <= !pins.modePinLevel;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      stop_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd4e28c30));
    pins.enablePin = 1'b1;
    pins.outputOk = 1'b1;
    pins.cycleDemand = 1'b1;
    tick(10);
    rst_n <= 1'b1;
    bus(REG_CTRL, 0, 0, 32'h1, '1);
    bus(REG_PERIOD, 0, 0, 32'h1f4, '1);
    bus(REG_DEAD, 0, 0, 32'h2, '1);
    bus(4'h2, 0, 0, 32'h0, '1);
    bus(REG_STATUS, 1, '1, 0, 0);
    bus(REG_STATUS, 0, 0, 32'h0, 32'h1);
    bus(REG_PERIOD, 1, 32'd50, 0, 0);
    bus(REG_DEAD, 1, 32'd5, 0, 0);
    bus(REG_DEAD, 0, 0, 32'h5, '1);
    for (int c = 0; c < 5; c++) begin
      logic [3:0] st;
      st = {c == 4, c == 1 || c == 3, c >= 2, 1'b1};
      pins.intCompDetected <= 1'($urandom);
      relatch(3'(c));
      chk(32'(intComp), 32'(c < 2 && pins.intCompDetected));
      bus(REG_STATUS, 0, 0, 32'(st), 32'hf);
      chk(32'(spread), 32'(st[2]));
      chk(32'(errAmp), 32'(c != 4));
      pins.cfgCode <= 3'($urandom % 5);
      pins.cfgPinHigh <= 1'b1;
      tick(12);
      bus(REG_STATUS, 0, 0, {27'h0, 1'b1, st}, 32'h1f);
      pins.cfgPinHigh <= 1'b0;
      pins.cfgPinLow <= 1'b1;
      tick(12);
      bus(REG_STATUS, 0, 0, {27'h0, 1'b0, st}, 32'h1f);
      pins.cfgPinLow <= 1'b0;
    end
    for (int c = 0; c < 2; c++) begin
      relatch(3'(c));
      syncOn <= 1'b1;
      tick(500);
      bus(REG_STATUS, 0, 0, 32'(c == 0) << 6, 32'h40);
      syncOn <= 1'b0;
      pins.modePinLevel <= 1'b0;
      tick(250);
    end
    relatch(CFG_P_NOSS_DUAL);
    nHs = 0;
    nLs = 0;
    nPg = 0;
    tick(700);
    chk(32'(nHs >= 10 && nLs >= 10), 32'h1);
    chk(32'(pgOe), 32'h1);
    chk(32'(nPg >= 10), 32'h1);
    pins.modePinLevel <= 1'b1;
    pins.cycleDemand <= 1'b0;
    tick(1200);
    chk(32'(pgOe), 32'h0);
    chk(32'(slp), 32'h1);
    bus(REG_STATUS, 0, 0, 32'h80, 32'h80);
    pins.cycleDemand <= 1'b1;
    pins.reverseCurrent <= 1'b1;
    tick(300);
    chk(32'(slp), 32'h0);
    pins.reverseCurrent <= 1'b0;
    pins.modePinLevel <= 1'b0;
    pins.cycleDemand <= 1'b0;
    tick(1200);
    chk(32'(slp), 32'h0);
    pins.cycleDemand <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i[0]) pins.enablePin <= 1'b0;
      else pins.overTemp <= 1'b1;
      tick(20);
      chk(32'(ssHold), 32'h1);
      chk(32'(hs | ls), 32'h0);
      chk(32'(regEn), 32'(i[0]));
      pins.enablePin <= 1'b1;
      pins.overTemp <= 1'b0;
      pins.tempRecovered <= !i[0];
      tick(20);
      chk(32'(ssHold), 32'h0);
      chk(32'(regEn), 32'h1);
      pins.tempRecovered <= 1'b0;
    end
    stop_test();
  end
endmodule // bms_buck_controller_mode_sequencer_test
bind bms_buck_controller_mode_sequencer bms_asserts i_chk (.clk(clk), .rst_n(rst_n),
  .pinsIn(pinsIn), .highSideDrive(highSideDrive), .lowSideDrive(lowSideDrive),
  .powerGoodPhaseOut(powerGoodPhaseOut), .errAmpEnable(errAmpEnable),
  .intCompEnable(intCompEnable), .activeNoiseFilter(activeNoiseFilter),
  .sleepState(sleepState), .softStartHold(softStartHold), .gateRegEnable(gateRegEnable),
  .spreadEnable(spreadEnable));
